// ==== rtl/bit_pair_map.sv ====
// Purpose: pairs half-word bits onto chips and back
// Assumes: 32 data bits and 6 check bits of one half word, local numbering
// Notes: same map for lower and upper halves
`timescale 1ns/1ps
`include "flaw_defs.svh"

module bit_pair_map (
  input wire logic [`SCF_HALF_DATA_W-1:0] wr_data,
  input wire logic [`SCF_HALF_CHECK_W-1:0] wr_check,
  output flaw_pkg::pair_word_t wr_pairs,
  input wire flaw_pkg::pair_word_t rd_pairs,
  output logic [`SCF_HALF_DATA_W-1:0] rd_data,
  output logic [`SCF_HALF_CHECK_W-1:0] rd_check
);
  import flaw_pkg::*;

  genvar c;
  generate
    // data chips hold bits sixteen apart
    for (c = 0; c < `SCF_DATA_PAIR_CHIPS; c++) begin : g_data
      assign wr_pairs[c] = {wr_data[c+`SCF_DATA_PAIR_GAP], wr_data[c]};
      assign rd_data[c] = rd_pairs[c][0];
      assign rd_data[c+`SCF_DATA_PAIR_GAP] = rd_pairs[c][1];
    end
    // check chips hold bits three apart
    for (c = 0; c < `SCF_CHECK_PAIR_CHIPS; c++) begin : g_check
      assign wr_pairs[c+`SCF_DATA_PAIR_CHIPS] = {wr_check[c+`SCF_CHECK_PAIR_GAP], wr_check[c]};
      assign rd_check[c] = rd_pairs[c+`SCF_DATA_PAIR_CHIPS][0];
      assign rd_check[c+`SCF_CHECK_PAIR_GAP] = rd_pairs[c+`SCF_DATA_PAIR_CHIPS][1];
    end
  endgenerate
endmodule

// ==== rtl/flaw_defs.svh ====
// Purpose: named constants of the spare-chip flaw steering block
// Assumes: included by bare name from every design file that needs a figure
// Notes: definitions only
`ifndef FLAW_DEFS_SVH
`define FLAW_DEFS_SVH

// ****************************************************************
// stack geometry
// ****************************************************************
`define SCF_QUARTERS 4
`define SCF_DATA_CHIPS 19
`define SCF_CHIP_SLOTS 20
`define SCF_SPARE_SLOT 19
`define SCF_SPARE_NUMBER 5'h17
`define SCF_CHIP_W 5
`define SCF_BITS_PER_CHIP 2

// ****************************************************************
// bit pairing inside one half word
// ****************************************************************
`define SCF_HALF_DATA_W 32
`define SCF_HALF_CHECK_W 6
`define SCF_DATA_PAIR_CHIPS 16
`define SCF_DATA_PAIR_GAP 16
`define SCF_CHECK_PAIR_CHIPS 3
`define SCF_CHECK_PAIR_GAP 3

// ****************************************************************
// banks: quarter q serves octal bank n, n+4, n+10, n+14
// ****************************************************************
`define SCF_BANK_W 4
`define SCF_BASE_W 2
`define SCF_BASE_LSB 0
`define SCF_BASE_MSB 1
`define SCF_QSEL_LSB 2
`define SCF_QSEL_MSB 3

`endif

// ==== rtl/flaw_pkg.sv ====
// Purpose: types shared by the flaw steering modules
// Assumes: flaw_defs.svh supplies the sizes
// Notes: a pair is the two bits that live on one chip
`include "flaw_defs.svh"

package flaw_pkg;
  typedef logic [`SCF_BITS_PER_CHIP-1:0] pair_t;
  typedef pair_t [`SCF_DATA_CHIPS-1:0] pair_word_t;
  typedef pair_t [`SCF_CHIP_SLOTS-1:0] lane_word_t;
  typedef logic [`SCF_CHIP_W-1:0] chip_t;
  typedef logic [`SCF_BANK_W-1:0] bank_t;
  typedef logic [`SCF_BASE_W-1:0] quarter_t;

  typedef enum logic [1:0] {
    FLAW_NONE = 2'h1,
    FLAW_HELD = 2'h2
  } flaw_state_e;
endpackage

// ==== rtl/flaw_shift_steer.sv ====
// Purpose: cascaded flaw shift for one quarter-stack, write and read
// Assumes: flaw setting is stable while traffic flows
// Notes: both directions registered, one cycle each
`timescale 1ns/1ps
`include "flaw_defs.svh"

module flaw_shift_steer (
  input wire logic ref_clk,
  input wire logic rst,
  steer_if.steer sif
);
  import flaw_pkg::*;

  lane_word_t next_lanes;
  pair_word_t next_pairs;

  genvar k;
  generate
    for (k = 0; k < `SCF_DATA_CHIPS; k++) begin : g_chip
      localparam chip_t KC = chip_t'(k);
      // chips below the flaw keep their bits; the flawed chip and above pass upward
      if (k == 0) begin : g_first
        assign next_lanes[k] = (sif.flaw_on && KC >= sif.flaw_chip) ? '0 : sif.wr_pairs[k];
      end else begin : g_rest
        // the copied neighbour pair feeds a shifted chip
        assign next_lanes[k] = (sif.flaw_on && KC > sif.flaw_chip) ? sif.wr_pairs[k-1] :
                               (sif.flaw_on && KC == sif.flaw_chip) ? '0 : sif.wr_pairs[k];
      end
      // reads undo the shift so the corrector sees the normal layout
      assign next_pairs[k] = (sif.flaw_on && KC >= sif.flaw_chip) ? sif.rd_lanes[k+1] : sif.rd_lanes[k];
    end
  endgenerate

  // spare carries the last pair while a flaw pushes it there, and zeros otherwise
  assign next_lanes[`SCF_SPARE_SLOT] = sif.flaw_on ? sif.wr_pairs[`SCF_DATA_CHIPS-1] : '0;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sif.chip_lanes <= '0;
    end else begin
      sif.chip_lanes <= next_lanes;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sif.rd_pairs <= '0;
    end else begin
      sif.rd_pairs <= next_pairs;
    end
  end
endmodule

// ==== rtl/spare_chip_flaw_shift.sv ====
// Purpose: spare-chip flaw steering for the four quarters of one memory stack
// Assumes: maintenance side sets flaws between references; inputs synchronous to ref_clk
// Notes: write lanes one cycle after the request, read data two cycles after
`timescale 1ns/1ps
`include "flaw_defs.svh"

// How it works
// - four spares, one per stack quarter
// - quarter has nineteen data chips, one spare
// - one flaw per quarter, later ones refused
// - flawed chip bits move to next chip
// - shift cascades upward, ending on spare 23
// - chips below the flaw stay unchanged
// - upper half quarters shift identically
// - data chip holds bits sixteen apart
// - check chip holds bits three apart
// - each quarter serves exactly one bank
// - quarters serve banks n, n+4, n+10, n+14
// - duplicated write bits feed shifted positions
// - read data per bank includes spare bits
module spare_chip_flaw_shift (
  input wire logic ref_clk,
  input wire logic rst,
  input wire flaw_pkg::quarter_t base_bank,
  input wire logic cfg_set,
  input wire logic cfg_clear,
  input wire flaw_pkg::quarter_t cfg_quarter,
  input wire flaw_pkg::chip_t cfg_chip,
  input wire logic wr_valid,
  input wire flaw_pkg::bank_t wr_bank,
  input wire logic [`SCF_HALF_DATA_W-1:0] wr_data,
  input wire logic [`SCF_HALF_CHECK_W-1:0] wr_check,
  input wire logic rd_valid,
  input wire flaw_pkg::bank_t rd_bank,
  input wire flaw_pkg::lane_word_t rd_chip_data,
  output logic [`SCF_QUARTERS-1:0] chip_wr_en,
  output flaw_pkg::lane_word_t chip_wr_data [`SCF_QUARTERS],
  output logic rd_out_valid,
  output logic [`SCF_HALF_DATA_W-1:0] rd_out_data,
  output logic [`SCF_HALF_CHECK_W-1:0] rd_out_check,
  output logic [`SCF_QUARTERS-1:0] flaw_active,
  output logic flaw_refused
);
  import flaw_pkg::*;

  // ****************************************************************
  // bank decode
  // ****************************************************************
  // the low bank bits pick the stack, the high ones the quarter
  function automatic logic bank_hit(input bank_t bank, input quarter_t base);
    bank_hit = (bank[`SCF_BASE_MSB:`SCF_BASE_LSB] == base);
  endfunction

  function automatic quarter_t bank_quarter(input bank_t bank);
    bank_quarter = bank[`SCF_QSEL_MSB:`SCF_QSEL_LSB];
  endfunction

  // ****************************************************************
  // per-quarter flaw settings
  // ****************************************************************
  flaw_state_e state [`SCF_QUARTERS];
  chip_t flaw_chip [`SCF_QUARTERS];
  logic [`SCF_QUARTERS-1:0] set_refused;

  steer_if sif [`SCF_QUARTERS] ();
  pair_word_t wr_pairs;
  pair_word_t sel_rd_pairs;
  logic [`SCF_HALF_DATA_W-1:0] next_rd_data;
  logic [`SCF_HALF_CHECK_W-1:0] next_rd_check;

  genvar q;
  generate
    for (q = 0; q < `SCF_QUARTERS; q++) begin : g_quarter
      localparam quarter_t QI = quarter_t'(q);
      logic sel;
      assign sel = cfg_set && (cfg_quarter == QI);
      // refused when a flaw is already held or the chip is not a data chip
      assign set_refused[q] = sel && ((state[q] == FLAW_HELD) ||
                              (cfg_chip >= chip_t'(`SCF_DATA_CHIPS)));

      always_ff @(posedge ref_clk) begin
        if (rst) begin
          state[q] <= FLAW_NONE;
        end else begin
          unique case (state[q])
            FLAW_NONE: begin
              if (sel && !set_refused[q]) begin
                state[q] <= FLAW_HELD;
              end
            end
            FLAW_HELD: begin
              // clearing is the only way besides reset to free the spare again
              if (cfg_clear && cfg_quarter == QI) begin
                state[q] <= FLAW_NONE;
              end
            end
          endcase
        end
      end

      always_ff @(posedge ref_clk) begin
        if (rst) begin
          flaw_chip[q] <= '0;
        end else if (sel && !set_refused[q]) begin
          flaw_chip[q] <= cfg_chip;
        end
      end

      always_ff @(posedge ref_clk) begin
        if (rst) begin
          flaw_active[q] <= 1'b0;
        end else begin
          flaw_active[q] <= (state[q] == FLAW_HELD);
        end
      end

      // every quarter sees the same pairs; only the addressed one is enabled
      assign sif[q].flaw_on = (state[q] == FLAW_HELD);
      assign sif[q].flaw_chip = flaw_chip[q];
      assign sif[q].wr_pairs = wr_pairs;
      assign sif[q].rd_lanes = rd_chip_data;
      assign chip_wr_data[q] = sif[q].chip_lanes;

      flaw_shift_steer u_steer (
        .ref_clk(ref_clk),
        .rst(rst),
        .sif(sif[q])
      );

      always_ff @(posedge ref_clk) begin
        if (rst) begin
          chip_wr_en[q] <= 1'b0;
        end else begin
          chip_wr_en[q] <= wr_valid && bank_hit(wr_bank, base_bank) && (bank_quarter(wr_bank) == QI);
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flaw_refused <= 1'b0;
    end else begin
      flaw_refused <= |set_refused;
    end
  end

  // ****************************************************************
  // write pairing
  // ****************************************************************
  bit_pair_map u_map (
    .wr_data(wr_data),
    .wr_check(wr_check),
    .wr_pairs(wr_pairs),
    .rd_pairs(sel_rd_pairs),
    .rd_data(next_rd_data),
    .rd_check(next_rd_check)
  );

  // ****************************************************************
  // read return
  // ****************************************************************
  // read pairs are picked a cycle late, so the quarter select is staged too
  logic rd_stage;
  quarter_t rd_q;
  pair_word_t rd_pick [`SCF_QUARTERS];

  generate
    for (q = 0; q < `SCF_QUARTERS; q++) begin : g_pick
      assign rd_pick[q] = sif[q].rd_pairs;
    end
  endgenerate

  assign sel_rd_pairs = rd_pick[rd_q];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_stage <= 1'b0;
      rd_q <= '0;
    end else begin
      rd_stage <= rd_valid && bank_hit(rd_bank, base_bank);
      rd_q <= bank_quarter(rd_bank);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_out_valid <= 1'b0;
      rd_out_data <= '0;
      rd_out_check <= '0;
    end else begin
      rd_out_valid <= rd_stage;
      // corrector downstream needs the native layout: same-chip pairs are split back to their own bit positions
      rd_out_data <= next_rd_data;
      rd_out_check <= next_rd_check;
    end
  end
endmodule

// ==== rtl/steer_if.sv ====
// Purpose: carrier between the top and one quarter's shift steering
// Assumes: one instance per quarter-stack
// Notes: ctl side owns the flaw setting, steer side owns the shifted data
`timescale 1ns/1ps

interface steer_if;
  import flaw_pkg::*;
  logic flaw_on;
  chip_t flaw_chip;
  pair_word_t wr_pairs;
  lane_word_t chip_lanes;
  lane_word_t rd_lanes;
  pair_word_t rd_pairs;

  modport ctl (
    output flaw_on,
    output flaw_chip,
    output wr_pairs,
    output rd_lanes,
    input chip_lanes,
    input rd_pairs
  );
  modport steer (
    input flaw_on,
    input flaw_chip,
    input wr_pairs,
    input rd_lanes,
    output chip_lanes,
    output rd_pairs
  );
endinterface

// ==== verification/mem_chip_model.sv ====
// Purpose: memory chips of the four quarter-stacks, one word each
// Assumes: read data wanted in the cycle of the read request
// Notes: slot 19 is the spare chip
`timescale 1ns/1ps
`include "flaw_defs.svh"
module mem_chip_model (
  input wire logic ref_clk,
  input wire logic [`SCF_QUARTERS-1:0] chip_wr_en,
  input wire flaw_pkg::lane_word_t chip_wr_data [`SCF_QUARTERS],
  input wire logic rd_valid,
  input wire flaw_pkg::bank_t rd_bank,
  output flaw_pkg::lane_word_t rd_chip_data
);
  import flaw_pkg::*;
  lane_word_t cells [`SCF_QUARTERS];
  lane_word_t last = '0;
  always @(posedge ref_clk) begin
    for (int q = 0; q < `SCF_QUARTERS; q++) begin
      if (chip_wr_en[q]) begin
        cells[q] <= chip_wr_data[q];
      end
    end
    if (rd_valid) begin
      last <= rd_chip_data;
    end
  end
  // unselected chips show the inverse so stale data never passes for valid
  assign rd_chip_data = rd_valid ? cells[rd_bank[3:2]] : ~last;
endmodule

// ==== verification/spare_flaw_monitor.sv ====
// Purpose: port checker for the spare-chip flaw steering top
// Assumes: one clock domain, flaws stable while traffic flows
// Notes: lane checks watch quarter 0 only, to keep the cost low
`timescale 1ns/1ps
`include "flaw_defs.svh"
module spare_flaw_monitor (
  input wire logic ref_clk,
  input wire logic rst,
  input wire flaw_pkg::quarter_t base_bank,
  input wire logic cfg_set,
  input wire logic cfg_clear,
  input wire flaw_pkg::quarter_t cfg_quarter,
  input wire flaw_pkg::chip_t cfg_chip,
  input wire logic wr_valid,
  input wire flaw_pkg::bank_t wr_bank,
  input wire logic [`SCF_HALF_DATA_W-1:0] wr_data,
  input wire logic [`SCF_HALF_CHECK_W-1:0] wr_check,
  input wire logic rd_valid,
  input wire flaw_pkg::bank_t rd_bank,
  input wire logic [`SCF_QUARTERS-1:0] chip_wr_en,
  input wire flaw_pkg::lane_word_t chip_wr_data [`SCF_QUARTERS],
  input wire logic rd_out_valid,
  input wire logic [`SCF_QUARTERS-1:0] flaw_active,
  input wire logic flaw_refused
);
  import flaw_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ****
  // checks
  // ****
  // flaw_active trails the steering state by one cycle, so it mirrors the state a write was taken under
  wr_enable_a: assert property (
    wr_valid && wr_bank[1:0] == base_bank |=> chip_wr_en == 4'h1 << $past(wr_bank[3:2])) else $error("write enable");
  rd_latency_a: assert property (
    rd_valid && rd_bank[1:0] == base_bank |-> ##2 rd_out_valid) else $error("read latency");
  rd_cause_a: assert property (
    rd_out_valid |-> $past(rd_valid, 2) && $past(rd_bank[1:0], 2) == base_bank) else $error("stray read");
  flaw_take_a: assert property (
    cfg_set && !cfg_clear && cfg_chip < 5'h13 && !flaw_active[cfg_quarter]
    && !($past(cfg_set) && $past(cfg_quarter) == cfg_quarter)
    |=> !flaw_refused ##1 flaw_active[$past(cfg_quarter, 2)]) else $error("flaw not taken");
  flaw_refuse_a: assert property (
    cfg_set && !cfg_clear && flaw_active[cfg_quarter]
    && !($past(cfg_clear) && $past(cfg_quarter) == cfg_quarter) |=> flaw_refused) else $error("second flaw");
  flaw_hold_a: assert property (
    $fell(flaw_active[0]) |-> $past(cfg_clear, 2) && $past(cfg_quarter, 2) == 2'h0) else $error("flaw lost");
  spare_idle_a: assert property (
    chip_wr_en[0] && !flaw_active[0] |-> chip_wr_data[0][19] == 2'h0) else $error("spare written");
  data_pair_a: assert property (
    chip_wr_en[0] && !flaw_active[0] |-> chip_wr_data[0][0] == {$past(wr_data[16]), $past(wr_data[0])})
    else $error("data pair");
  spare_fill_a: assert property (
    chip_wr_en[0] && flaw_active[0] |-> chip_wr_data[0][19] == {$past(wr_check[5]), $past(wr_check[2])})
    else $error("spare lane");
endmodule
bind spare_chip_flaw_shift spare_flaw_monitor mon (.ref_clk, .rst, .base_bank, .cfg_set, .cfg_clear,
  .cfg_quarter, .cfg_chip, .wr_valid, .wr_bank, .wr_data, .wr_check, .rd_valid, .rd_bank, .chip_wr_en,
  .chip_wr_data, .rd_out_valid, .flaw_active, .flaw_refused);

// ==== verification/tb.sv ====
// Purpose: self-checking bench for spare-chip flaw steering
// Assumes: chip model answers reads in the same cycle
// Notes: flaws change only between transfers
`timescale 1ns/1ps
`include "flaw_defs.svh"
module tb;
  import flaw_pkg::*;
  logic ref_clk = 0;
  logic rst = 1;
  quarter_t base_bank = 2'h2;
  logic cfg_set = 0;
  logic cfg_clear = 0;
  quarter_t cfg_quarter = '0;
  chip_t cfg_chip = '0;
  logic wr_valid = 0;
  bank_t wr_bank = '0;
  logic [31:0] wr_data = '0;
  logic [5:0] wr_check = '0;
  logic rd_valid = 0;
  bank_t rd_bank = '0;
  lane_word_t rd_chip_data;
  logic [3:0] chip_wr_en;
  lane_word_t chip_wr_data [4];
  logic rd_out_valid;
  logic [31:0] rd_out_data;
  logic [5:0] rd_out_check;
  logic [3:0] flaw_active;
  logic flaw_refused;
  int failures = 0;
  int checks_done = 0;
  logic [15:0] seed = 16'h0038;
  int flaw_of [4] = '{-1, -1, -1, -1};
  int pick [4] = '{0, 6, 18, 11};
  logic [37:0] exp_q [$];
  always #12.5 ref_clk = ~ref_clk;
  spare_chip_flaw_shift dut (.ref_clk, .rst, .base_bank, .cfg_set, .cfg_clear, .cfg_quarter, .cfg_chip,
    .wr_valid, .wr_bank, .wr_data, .wr_check, .rd_valid, .rd_bank, .rd_chip_data, .chip_wr_en,
    .chip_wr_data, .rd_out_valid, .rd_out_data, .rd_out_check, .flaw_active, .flaw_refused);
  mem_chip_model chips (.ref_clk, .chip_wr_en, .chip_wr_data, .rd_valid, .rd_bank, .rd_chip_data);
  // ****
  // model and helpers
  // ****
  function automatic logic [31:0] next_rand();
    logic [31:0] r;
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    r[15:0] = seed;
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    r[31:16] = seed;
    return r;
  endfunction
  function automatic lane_word_t exp_lanes(input logic [31:0] d, input logic [5:0] c, input int f);
    pair_word_t p;
    lane_word_t l;
    for (int k = 0; k < 19; k++) begin
      p[k] = k < 16 ? {d[k + 16], d[k]} : {c[k - 13], c[k - 16]};
    end
    for (int k = 0; k < 20; k++) begin
      if (k < 19 && (f < 0 || k < f)) begin
        l[k] = p[k];
      end else if (f >= 0 && k > f) begin
        l[k] = p[k - 1];
      end else begin
        l[k] = 2'h0;
      end
    end
    return l;
  endfunction
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cfg(input logic s, input logic c, input quarter_t q, input chip_t ch);
    logic refuse;
    logic [3:0] act;
    // a held quarter refuses a set even beside a clear; on a free quarter the set wins
    refuse = s && (flaw_of[q] >= 0 || ch >= 5'h13);
    if (s && !refuse) begin
      flaw_of[q] = ch;
    end else if (c) begin
      flaw_of[q] = -1;
    end
    for (int i = 0; i < 4; i++) begin
      act[i] = flaw_of[i] >= 0;
    end
    cfg_set <= s;
    cfg_clear <= c;
    cfg_quarter <= q;
    cfg_chip <= ch;
    @(posedge ref_clk);
    cfg_set <= 1'b0;
    cfg_clear <= 1'b0;
    #1;
    chk("refused", 64'(flaw_refused), 64'(refuse));
    @(posedge ref_clk);
    #1;
    // the active flags trail the taken setting by one more cycle
    chk("refused pulse", 64'(flaw_refused), 64'h0);
    chk("active", 64'(flaw_active), 64'(act));
    @(posedge ref_clk);
  endtask
  task automatic xfer(input quarter_t q, input quarter_t stack);
    logic [31:0] d;
    logic [31:0] c;
    d = next_rand();
    c = next_rand();
    wr_valid <= 1'b1;
    wr_bank <= {q, stack};
    wr_data <= d;
    wr_check <= c[5:0];
    rd_valid <= stack != base_bank;
    rd_bank <= {q, stack};
    @(posedge ref_clk);
    wr_valid <= 1'b0;
    rd_valid <= 1'b0;
    #1;
    chk("enable", 64'(chip_wr_en), stack == base_bank ? 64'(4'h1 << q) : 64'h0);
    if (stack == base_bank) begin
      chk("lanes", 64'(chip_wr_data[q]), 64'(exp_lanes(d, c[5:0], flaw_of[q])));
      exp_q.push_back({c[5:0], d});
      @(posedge ref_clk);
      rd_valid <= 1'b1;
      @(posedge ref_clk);
      rd_valid <= 1'b0;
    end
    // the read answer stands in the second cycle after the taking edge
    @(posedge ref_clk);
    #1;
    chk("read valid", 64'(rd_out_valid), 64'(stack == base_bank));
    if (stack == base_bank) begin
      chk("read word", 64'({rd_out_check, rd_out_data}), 64'(exp_q.pop_front()));
    end
    @(posedge ref_clk);
  endtask
  task print_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ****
  // tests
  // ****
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk("reset active", 64'(flaw_active), 64'h0);
    @(posedge ref_clk);
    for (int q = 0; q < 4; q++) begin
      xfer(q[1:0], base_bank);
    end
    xfer(2'h0, ~base_bank);
    $display("test native done");
    for (int q = 0; q < 4; q++) begin
      cfg(1'b1, 1'b0, q[1:0], pick[q][4:0]);
      xfer(q[1:0], base_bank);
    end
    $display("test shift done");
    cfg(1'b1, 1'b0, 2'h1, 5'h03);
    cfg(1'b0, 1'b1, 2'h3, 5'h00);
    cfg(1'b1, 1'b0, 2'h3, 5'h13);
    xfer(2'h3, base_bank);
    cfg(1'b0, 1'b1, 2'h0, 5'h00);
    xfer(2'h0, base_bank);
    $display("test refuse done");
    print_verdict;
  end
  // whole run needs about 90 cycles; far beyond that means a hang
  initial begin
    repeat (2000) @(posedge ref_clk);
    failures++;
    print_verdict;
  end
endmodule
